//--- mgeh_pkg.sv
// Shared constants for the event handshake link
package mgeh_pkg;
   localparam int MGEH_KIND_W = 2;
   localparam int MGEH_CMD_W = 8;
   localparam logic [1:0] MGEH_KIND_XFER = 2'h1;
   localparam logic [7:0] MGEH_CMD_OUTWARD = 8'h01;
   localparam logic [7:0] MGEH_CMD_INWARD = 8'h02;
   localparam int MGEH_CLK_NS = 25;
   localparam int MGEH_PULSE_NS = 200;
   localparam int MGEH_PULSE_CYC = (MGEH_PULSE_NS + MGEH_CLK_NS - 1) / MGEH_CLK_NS;
   localparam int MGEH_CNT_W = 8;
   localparam logic [7:0] MGEH_CNT_ONE = 8'h01;
   localparam logic [7:0] MGEH_CNT_ZERO = 8'h00;
endpackage : mgeh_pkg

//--- mgeh_if.sv
// Pin-level interface joining the two ends of the event handshake link
`timescale 1ns/10ps
`default_nettype none
interface mgeh_if;
   import mgeh_pkg::*;
   // Channel toward the communications device (inbound)
   logic in_strobe;
   logic in_ack;
   logic [1:0] in_kind;
   logic [7:0] in_cmd;
   // Channel toward the safety processor (outbound)
   logic out_strobe;
   logic out_ack;
   logic [1:0] out_kind;
   logic [7:0] out_cmd;
   modport dev (
      input in_strobe, in_kind, in_cmd, out_ack,
      output in_ack, out_strobe, out_kind, out_cmd
   );
   modport partner (
      output in_strobe, in_kind, in_cmd, out_ack,
      input in_ack, out_strobe, out_kind, out_cmd
   );
endinterface : mgeh_if
`default_nettype wire

//--- mgeh_dev.sv
// Communications-device end of the event handshake link
// Behaviour
// RULE_01: One edge input plus eleven level outputs
// RULE_02: Two independent channels, one each way
// RULE_03: Inbound 01b/01 outward, 01b/02 inward request
// RULE_04: Outbound 01b/01 and 01b/02 announce readiness
// RULE_05: Undefined codes never sent, treated as none
// RULE_06: Set kind and code before strobe
// RULE_07: Strobe low, high, low: one pulse
// RULE_08: Receiver detects strobe rising edge
// RULE_09: Sender waits ack rising edge, then ends
// RULE_10: Receiver captures kind and code on edge
// RULE_11: Receiver raises ack after capture
// RULE_12: Action performed while ack is high
// RULE_13: Ack falls when action finishes
// RULE_14: Ack edge starts response, strobe edge receive
// RULE_15: Hold lines until ack; pulse width configurable
// RULE_16: Synchronise inputs; flag undefined codes
`timescale 1ns/10ps
`default_nettype none
module mgeh_dev
   import mgeh_pkg::*;
#(
   parameter logic [7:0] PULSE_CYC = 8'(MGEH_PULSE_CYC)
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Link pins
   mgeh_if.dev link,
   // Received request side
   output logic o_req_outward,
   output logic o_req_inward,
   output logic o_req_error,
   input wire logic i_req_done,
   // Ready announcement side
   input wire logic i_rdy_valid,
   input wire logic i_rdy_inward,
   output logic o_rdy_busy,
   output logic o_rdy_done
);
   typedef enum logic [1:0] {RX_IDLE, RX_ACT, RX_ERR} mgeh_rx_t;
   typedef enum logic [1:0] {TX_IDLE, TX_SETUP, TX_HIGH, TX_WAIT} mgeh_tx_t;

   // Input synchronisers
   logic stb_s1_q, stb_s2_q, stb_s3_q, ack_s1_q, ack_s2_q, ack_s3_q;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stb_s1_q <= 1'b0;
         stb_s2_q <= 1'b0;
         stb_s3_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end else begin
         // RULE_16 two-stage synchronise
         stb_s1_q <= link.in_strobe;
         stb_s2_q <= stb_s1_q;
         stb_s3_q <= stb_s2_q;
         ack_s1_q <= link.out_ack;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end
   logic stb_rise, ack_rise;
   // RULE_08 strobe rising edge
   assign stb_rise = stb_s2_q & ~stb_s3_q;
   // RULE_14 ack edge starts response
   assign ack_rise = ack_s2_q & ~ack_s3_q;

   // Receive channel
   mgeh_rx_t rx_q, rx_d;
   logic ack_q, ack_d, out_q, out_d, in_q, in_d, err_q, err_d;
   always_comb begin
      rx_d = rx_q;
      ack_d = ack_q;
      out_d = 1'b0;
      in_d = 1'b0;
      err_d = 1'b0;
      case (rx_q)
         RX_IDLE: begin
            // RULE_14 strobe edge starts receive
            if (stb_rise) begin
               // RULE_10 capture kind and code
               // RULE_03 decode inbound commands
               if (link.in_kind == MGEH_KIND_XFER && link.in_cmd == MGEH_CMD_OUTWARD) begin
                  out_d = 1'b1;
                  rx_d = RX_ACT;
               end else if (link.in_kind == MGEH_KIND_XFER && link.in_cmd == MGEH_CMD_INWARD) begin
                  in_d = 1'b1;
                  rx_d = RX_ACT;
               end else begin
                  // RULE_05 undefined carries no command
                  // RULE_16 flag undefined code
                  err_d = 1'b1;
                  rx_d = RX_ERR;
               end
               // RULE_11 raise ack after capture
               ack_d = 1'b1;
            end
         end
         RX_ACT: begin
            // RULE_12 action held while ack high
            out_d = out_q;
            in_d = in_q;
            // RULE_13 drop ack when done
            if (i_req_done) begin
               ack_d = 1'b0;
               out_d = 1'b0;
               in_d = 1'b0;
               rx_d = RX_IDLE;
            end
         end
         RX_ERR: begin
            ack_d = 1'b0;
            rx_d = RX_IDLE;
         end
         default: begin
            rx_d = RX_IDLE;
            ack_d = 1'b0;
         end
      endcase
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_q <= RX_IDLE;
         ack_q <= 1'b0;
         out_q <= 1'b0;
         in_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         rx_q <= rx_d;
         ack_q <= ack_d;
         out_q <= out_d;
         in_q <= in_d;
         err_q <= err_d;
      end
   end
   assign link.in_ack = ack_q;
   assign o_req_outward = out_q;
   assign o_req_inward = in_q;
   assign o_req_error = err_q;

   // Send channel
   // RULE_02 independent send channel
   mgeh_tx_t tx_q, tx_d;
   logic stb_q, stb_d, busy_q, busy_d, done_q, done_d, seen_q, seen_d;
   logic [1:0] kind_q, kind_d;
   logic [7:0] cmd_q, cmd_d, cnt_q, cnt_d;
   always_comb begin
      tx_d = tx_q;
      stb_d = stb_q;
      busy_d = busy_q;
      done_d = 1'b0;
      kind_d = kind_q;
      cmd_d = cmd_q;
      cnt_d = cnt_q;
      seen_d = seen_q;
      case (tx_q)
         TX_IDLE: begin
            if (i_rdy_valid) begin
               // RULE_04 readiness codes only
               // RULE_06 set lines before strobe
               kind_d = MGEH_KIND_XFER;
               cmd_d = i_rdy_inward ? MGEH_CMD_INWARD : MGEH_CMD_OUTWARD;
               busy_d = 1'b1;
               cnt_d = PULSE_CYC;
               seen_d = 1'b0;
               tx_d = TX_SETUP;
            end
         end
         TX_SETUP: begin
            cnt_d = cnt_q - MGEH_CNT_ONE;
            if (cnt_q == MGEH_CNT_ONE) begin
               // RULE_07 strobe goes high
               stb_d = 1'b1;
               cnt_d = PULSE_CYC;
               tx_d = TX_HIGH;
            end
         end
         TX_HIGH: begin
            // RULE_09 ack may rise before strobe falls
            if (ack_rise) begin
               seen_d = 1'b1;
            end
            cnt_d = cnt_q - MGEH_CNT_ONE;
            if (cnt_q == MGEH_CNT_ONE) begin
               // RULE_07 strobe back low
               stb_d = 1'b0;
               tx_d = TX_WAIT;
            end
         end
         TX_WAIT: begin
            // RULE_09 wait for ack rising edge
            // RULE_15 lines held until ack
            if (ack_rise || seen_q) begin
               busy_d = 1'b0;
               done_d = 1'b1;
               cnt_d = MGEH_CNT_ZERO;
               tx_d = TX_IDLE;
            end
         end
         default: begin
            tx_d = TX_IDLE;
            stb_d = 1'b0;
            busy_d = 1'b0;
         end
      endcase
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_q <= TX_IDLE;
         stb_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         kind_q <= 2'h0;
         cmd_q <= 8'h00;
         cnt_q <= MGEH_CNT_ZERO;
         seen_q <= 1'b0;
      end else begin
         tx_q <= tx_d;
         stb_q <= stb_d;
         busy_q <= busy_d;
         done_q <= done_d;
         kind_q <= kind_d;
         cmd_q <= cmd_d;
         cnt_q <= cnt_d;
         seen_q <= seen_d;
      end
   end
   // RULE_01 eleven level outputs
   assign link.out_strobe = stb_q;
   assign link.out_kind = kind_q;
   assign link.out_cmd = cmd_q;
   assign o_rdy_busy = busy_q;
   assign o_rdy_done = done_q;
endmodule : mgeh_dev
`default_nettype wire

//--- mgeh_partner.sv
// Safety-processor end of the event handshake link
`timescale 1ns/10ps
`default_nettype none
module mgeh_partner
   import mgeh_pkg::*;
#(
   parameter logic [7:0] PULSE_CYC = 8'(MGEH_PULSE_CYC)
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Link pins
   mgeh_if.partner link,
   // Request side
   input wire logic i_req_valid,
   input wire logic i_req_inward,
   output logic o_req_busy,
   output logic o_req_done,
   // Ready receipt side
   output logic o_rdy_outward,
   output logic o_rdy_inward,
   input wire logic i_rdy_done
);
   typedef enum logic [1:0] {PT_IDLE, PT_SETUP, PT_HIGH, PT_WAIT} mgeh_pt_t;
   typedef enum logic [1:0] {PR_IDLE, PR_ACT, PR_ERR} mgeh_pr_t;

   // Edge history on the incoming lines
   logic stb_p_q, ack_p_q;
   logic stb_rise, ack_rise;
   assign stb_rise = link.out_strobe & ~stb_p_q;
   assign ack_rise = link.in_ack & ~ack_p_q;

   // Request sender
   mgeh_pt_t tx_q, tx_d;
   logic stb_q, stb_d, busy_q, busy_d, done_q, done_d, seen_q, seen_d;
   logic [1:0] kind_q, kind_d;
   logic [7:0] cmd_q, cmd_d, cnt_q, cnt_d;
   always_comb begin
      tx_d = tx_q;
      stb_d = stb_q;
      busy_d = busy_q;
      done_d = 1'b0;
      kind_d = kind_q;
      cmd_d = cmd_q;
      cnt_d = cnt_q;
      seen_d = seen_q;
      case (tx_q)
         PT_IDLE: begin
            if (i_req_valid) begin
               // RULE_06 set lines before strobe
               kind_d = MGEH_KIND_XFER;
               cmd_d = i_req_inward ? MGEH_CMD_INWARD : MGEH_CMD_OUTWARD;
               busy_d = 1'b1;
               cnt_d = PULSE_CYC;
               seen_d = 1'b0;
               tx_d = PT_SETUP;
            end
         end
         PT_SETUP: begin
            cnt_d = cnt_q - MGEH_CNT_ONE;
            if (cnt_q == MGEH_CNT_ONE) begin
               // RULE_07 strobe high
               stb_d = 1'b1;
               cnt_d = PULSE_CYC;
               tx_d = PT_HIGH;
            end
         end
         PT_HIGH: begin
            // RULE_09 ack may rise before strobe falls
            if (ack_rise) begin
               seen_d = 1'b1;
            end
            cnt_d = cnt_q - MGEH_CNT_ONE;
            if (cnt_q == MGEH_CNT_ONE) begin
               stb_d = 1'b0;
               tx_d = PT_WAIT;
            end
         end
         PT_WAIT: begin
            // RULE_09 end on ack rising edge
            if (ack_rise || seen_q) begin
               busy_d = 1'b0;
               done_d = 1'b1;
               cnt_d = MGEH_CNT_ZERO;
               tx_d = PT_IDLE;
            end
         end
         default: begin
            tx_d = PT_IDLE;
            stb_d = 1'b0;
            busy_d = 1'b0;
         end
      endcase
   end

   // Ready receiver
   mgeh_pr_t rx_q, rx_d;
   logic ack_q, ack_d, ro_q, ro_d, ri_q, ri_d;
   always_comb begin
      rx_d = rx_q;
      ack_d = ack_q;
      ro_d = 1'b0;
      ri_d = 1'b0;
      case (rx_q)
         PR_IDLE: begin
            // RULE_08 strobe rising edge
            if (stb_rise) begin
               // RULE_10 capture and decode
               if (link.out_kind == MGEH_KIND_XFER && link.out_cmd == MGEH_CMD_OUTWARD) begin
                  ro_d = 1'b1;
                  rx_d = PR_ACT;
               end else if (link.out_kind == MGEH_KIND_XFER && link.out_cmd == MGEH_CMD_INWARD) begin
                  ri_d = 1'b1;
                  rx_d = PR_ACT;
               end else begin
                  // RULE_05 no command
                  rx_d = PR_ERR;
               end
               // RULE_11 raise ack
               ack_d = 1'b1;
            end
         end
         PR_ACT: begin
            // RULE_12 act while ack high
            ro_d = ro_q;
            ri_d = ri_q;
            // RULE_13 drop ack when done
            if (i_rdy_done) begin
               ack_d = 1'b0;
               ro_d = 1'b0;
               ri_d = 1'b0;
               rx_d = PR_IDLE;
            end
         end
         PR_ERR: begin
            ack_d = 1'b0;
            rx_d = PR_IDLE;
         end
         default: begin
            ack_d = 1'b0;
            rx_d = PR_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stb_p_q <= 1'b0;
         ack_p_q <= 1'b0;
         tx_q <= PT_IDLE;
         stb_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         kind_q <= 2'h0;
         cmd_q <= 8'h00;
         cnt_q <= MGEH_CNT_ZERO;
         seen_q <= 1'b0;
         rx_q <= PR_IDLE;
         ack_q <= 1'b0;
         ro_q <= 1'b0;
         ri_q <= 1'b0;
      end else begin
         stb_p_q <= link.out_strobe;
         ack_p_q <= link.in_ack;
         tx_q <= tx_d;
         stb_q <= stb_d;
         busy_q <= busy_d;
         done_q <= done_d;
         kind_q <= kind_d;
         cmd_q <= cmd_d;
         cnt_q <= cnt_d;
         seen_q <= seen_d;
         rx_q <= rx_d;
         ack_q <= ack_d;
         ro_q <= ro_d;
         ri_q <= ri_d;
      end
   end
   assign link.in_strobe = stb_q;
   assign link.in_kind = kind_q;
   assign link.in_cmd = cmd_q;
   assign link.out_ack = ack_q;
   assign o_req_busy = busy_q;
   assign o_req_done = done_q;
   assign o_rdy_outward = ro_q;
   assign o_rdy_inward = ri_q;
endmodule : mgeh_partner
`default_nettype wire

//--- mgeh_checker.sv
// Protocol checker for both channels of the event handshake link
`timescale 1ns/10ps
`default_nettype none
module mgeh_checker (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Inbound channel
   input wire logic in_strobe,
   input wire logic in_ack,
   input wire logic [1:0] in_kind,
   input wire logic [7:0] in_cmd,
   // Outbound channel
   input wire logic out_strobe,
   input wire logic out_ack,
   input wire logic [1:0] out_kind,
   input wire logic [7:0] out_cmd
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   property p_in_code;
      $rose(in_strobe) |-> in_kind == 2'h1 && (in_cmd == 8'h01 || in_cmd == 8'h02) && $stable({in_kind, in_cmd});
   endproperty
   a_in_code: assert property (p_in_code) else $error("inbound code not set before strobe");
   property p_out_code;
      $rose(out_strobe) |-> out_kind == 2'h1 && (out_cmd == 8'h01 || out_cmd == 8'h02) && $stable({out_kind, out_cmd});
   endproperty
   a_out_code: assert property (p_out_code) else $error("outbound code not set before strobe");
   // Bench pulse widths: eight cycles inbound, two outbound
   property p_in_pulse;
      $rose(in_strobe) |=> in_strobe [*7] ##1 !in_strobe;
   endproperty
   a_in_pulse: assert property (p_in_pulse) else $error("inbound strobe width wrong");
   property p_out_pulse;
      $rose(out_strobe) |=> out_strobe ##1 !out_strobe;
   endproperty
   a_out_pulse: assert property (p_out_pulse) else $error("outbound strobe width wrong");
   property p_in_ack;
      $rose(in_strobe) |-> ##[2:5] $rose(in_ack);
   endproperty
   a_in_ack: assert property (p_in_ack) else $error("inbound ack late");
   property p_out_ack;
      $rose(out_strobe) |-> ##[1:3] $rose(out_ack);
   endproperty
   a_out_ack: assert property (p_out_ack) else $error("outbound ack late");
   property p_in_hold;
      $rose(in_strobe) |-> $stable({in_kind, in_cmd}) [*5];
   endproperty
   a_in_hold: assert property (p_in_hold) else $error("inbound code changed early");
   property p_out_hold;
      $rose(out_strobe) |-> $stable({out_kind, out_cmd}) [*3];
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("outbound code changed early");
   c_in_ack: cover property ($rose(in_ack));
   c_out_ack: cover property ($rose(out_ack));
   c_in_inward: cover property (in_ack && in_cmd == 8'h02);
endmodule : mgeh_checker
`default_nettype wire

//--- test_mcu_gpio_event_handshake.sv
// Self-checking bench joining both ends of the event handshake link
`timescale 1ns/10ps
`default_nettype none
module test_mcu_gpio_event_handshake;
   import mgeh_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic req_valid = 1'b0, req_inward = 1'b0, rdy_valid = 1'b0, rdy_inward = 1'b0;
   logic req_done = 1'b0, rdy_done = 1'b0;
   logic d_out, d_in, d_err, e_out, e_in, e_err, p_out, p_in, p_done, d_done, p_busy, d_busy;
   logic [4:0] s_in, s_out, r_in, r_out, e_val;
   logic [4:0] prev_in = 5'h00, prev_out = 5'h00;
   logic [4:0] q_in[$], q_out[$];
   integer seed = 32'hD429;
   int fails = 0;
   int cmp_count = 0;
   int i;
   mgeh_if link();
   mgeh_if link_2();
   always #12.5 i_core_clk = ~i_core_clk;
   mgeh_dev #(.PULSE_CYC(8'h02)) i_mgeh_dev (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link),
      .o_req_outward(d_out), .o_req_inward(d_in), .o_req_error(d_err), .i_req_done(req_done),
      .i_rdy_valid(rdy_valid), .i_rdy_inward(rdy_inward), .o_rdy_busy(d_busy), .o_rdy_done(d_done));
   mgeh_partner i_mgeh_partner (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link),
      .i_req_valid(req_valid), .i_req_inward(req_inward), .o_req_busy(p_busy), .o_req_done(p_done),
      .o_rdy_outward(p_out), .o_rdy_inward(p_in), .i_rdy_done(rdy_done));
   mgeh_dev i_mgeh_dev_2 (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link_2),
      .o_req_outward(e_out), .o_req_inward(e_in), .o_req_error(e_err), .i_req_done(1'b1),
      .i_rdy_valid(1'b0), .i_rdy_inward(rdy_inward), .o_rdy_busy(), .o_rdy_done());
   mgeh_checker i_mgeh_checker (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .in_strobe(link.in_strobe),
      .in_ack(link.in_ack), .in_kind(link.in_kind), .in_cmd(link.in_cmd), .out_strobe(link.out_strobe),
      .out_ack(link.out_ack), .out_kind(link.out_kind), .out_cmd(link.out_cmd));
   task automatic finish_test();
      if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic check(input string nm, input logic [4:0] e, input logic [4:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   function automatic logic sig(input int sel);
      case (sel)
         0: return p_done;
         1: return d_done;
         2: return link_2.in_ack;
         3: return !link.in_ack;
         default: return !link.out_ack;
      endcase
   endfunction : sig
   task automatic wait_for(input int sel);
      int k;
      for (k = 0; k < 60 && sig(sel) !== 1'b1; k++) @(negedge i_core_clk);
      if (sig(sel) !== 1'b1) begin
         check("wait", 5'h01, 5'h00);
         finish_test();
      end
   endtask : wait_for
   task automatic send_in(input logic inward);
      wait_for(3);
      req_valid = 1'b1;
      req_inward = inward;
      q_in.push_back(inward ? 5'h08 : 5'h10);
      @(negedge i_core_clk);
      req_valid = 1'b0;
      check("request busy", 5'h01, {4'h0, p_busy});
      wait_for(0);
      check("request idle", 5'h00, {4'h0, p_busy});
   endtask : send_in
   task automatic send_out(input logic inward);
      wait_for(4);
      rdy_valid = 1'b1;
      rdy_inward = inward;
      q_out.push_back(inward ? 5'h01 : 5'h02);
      @(negedge i_core_clk);
      rdy_valid = 1'b0;
      check("ready busy", 5'h01, {4'h0, d_busy});
      wait_for(1);
      check("ready idle", 5'h00, {4'h0, d_busy});
   endtask : send_out
   task automatic bad_send(input logic [1:0] kind, input logic [7:0] cmd, input logic [4:0] exp);
      link_2.in_kind = kind;
      link_2.in_cmd = cmd;
      q_in.push_back(exp);
      repeat (2) @(negedge i_core_clk);
      link_2.in_strobe = 1'b1;
      repeat (2) @(negedge i_core_clk);
      link_2.in_strobe = 1'b0;
      wait_for(2);
      @(negedge i_core_clk);
      check("single ack", 5'h00, {4'h0, link_2.in_ack});
   endtask : bad_send
   // Result watcher: each rising result takes the oldest note
   always @(negedge i_core_clk) begin
      s_in = {d_out, d_in, d_err, e_err, e_out | e_in};
      s_out = {3'h0, p_out, p_in};
      r_in = s_in & ~prev_in;
      r_out = s_out & ~prev_out;
      prev_in = s_in;
      prev_out = s_out;
      if (i_rst_n && r_in != 5'h00) begin
         e_val = q_in.size() > 0 ? q_in.pop_front() : 5'h00;
         check("inbound event", e_val, r_in);
      end
      if (i_rst_n && r_out != 5'h00) begin
         e_val = q_out.size() > 0 ? q_out.pop_front() : 5'h00;
         check("outbound event", e_val, r_out);
      end
      if (d_out | d_in) check("ack during action", 5'h01, {4'h0, link.in_ack});
   end
   // Far-side action handlers finish after random delays
   always @(negedge i_core_clk) begin
      req_done <= (d_out | d_in) && !req_done && ($random(seed) & 3) == 0;
      rdy_done <= (p_out | p_in) && !rdy_done && ($random(seed) & 1) == 1;
   end
   initial begin
      link_2.in_strobe = 1'b0;
      link_2.out_ack = 1'b0;
      link_2.in_kind = 2'h0;
      link_2.in_cmd = 8'h00;
      repeat (5) @(negedge i_core_clk);
      i_rst_n = 1'b1;
      for (i = 0; i < 4; i++) send_in(i[0]);
      for (i = 0; i < 4; i++) send_out(i[0]);
      // Both channels busy at once
      for (i = 0; i < 8; i++) begin
         fork
            send_in(1'($random(seed)));
            send_out(1'($random(seed)));
         join
      end
      bad_send(2'h1, 8'h01, 5'h01);
      bad_send(2'h1, 8'h02, 5'h01);
      bad_send(2'h0, 8'h01, 5'h02);
      bad_send(2'h1, 8'h00, 5'h02);
      bad_send(2'h1, 8'h03, 5'h02);
      bad_send(2'h3, 8'h02, 5'h02);
      for (i = 0; i < 4; i++) bad_send({1'($random(seed)), 1'b0}, 8'($random(seed)), 5'h02);
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_core_clk);
      check("lines in reset", 5'h00, {link.in_ack, link.out_strobe, link.out_kind, d_out});
      i_rst_n = 1'b1;
      send_in(1'b1);
      send_out(1'b0);
      repeat (10) @(negedge i_core_clk);
      check("pending inbound", 5'h00, 5'(q_in.size()));
      check("pending outbound", 5'h00, 5'(q_out.size()));
      finish_test();
   end
endmodule : test_mcu_gpio_event_handshake
`default_nettype wire
